// File: shared/spio_pkg.sv
/*
 * constants for the shared parallel i/o ports: pin layout, register map, reset values
 * assumes a 32-bit ahb-lite register bus decoding the low 12 address bits
 */
package spio_pkg;
    localparam int          NUM_PORTS     = 7;
    localparam int          PIN_COUNT     = 38;
    localparam int          MAX_WIDTH     = 8;
    localparam int          PORT_WIDTH [NUM_PORTS] = '{4, 4, 6, 4, 8, 5, 7};
    localparam int          PORT_BASE  [NUM_PORTS] = '{0, 4, 8, 14, 18, 26, 31};
    localparam int          ADDR_W        = 12;
    localparam int          SYNC_STAGES   = 3;

    localparam logic [11:0] LOW_PAGE_BASE = 12'h000;
    localparam logic [11:0] LOW_STRIDE    = 12'h008;
    localparam logic [11:0] DATA_OFS      = 12'h000;
    localparam logic [11:0] DIR_OFS       = 12'h004;
    localparam logic [11:0] HIGH_PAGE_BASE = 12'h100;
    localparam logic [11:0] HIGH_STRIDE   = 12'h010;
    localparam logic [11:0] PULLUP_OFS    = 12'h000;
    localparam logic [11:0] SLEW_OFS      = 12'h004;
    localparam logic [11:0] DRIVE_OFS     = 12'h008;

    localparam logic [37:0] LATCH_RST     = 38'h00_0000_0000;
    localparam logic [37:0] DIR_RST       = 38'h00_0000_0000;
    localparam logic [37:0] PULLUP_RST    = 38'h00_0000_0000;
    localparam logic [37:0] SLEW_RST      = 38'h3F_FFFF_FFFF;
    localparam logic [37:0] DRIVE_RST     = 38'h00_0000_0000;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;

    typedef enum logic [2:0] {
        REG_DATA,
        REG_DIR,
        REG_PULLUP,
        REG_SLEW,
        REG_DRIVE
    } spio_reg_t;
endpackage : spio_pkg

// File: hdl/spio_sync.sv
/*
 * three-stage input synchroniser with agreement filter for the pad levels
 * assumes pad inputs are asynchronous to clk
 */
`timescale 1ns/10ps
module spio_sync #(
    parameter int WIDTH = 38
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (ce) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a bit only changes once stage two and three agree
    always_ff @(posedge clk) begin
        if (!rstn) begin
            level <= '0;
        end else if (ce) begin
            level <= (stage2 & stage3) | (level & (stage2 ^ stage3));
        end
    end
endmodule : spio_sync

// File: hdl/spio_pin_mux.sv
/*
 * per-pin priority mux between analog owner, digital peripheral and port logic
 * assumes claim inputs are already gated by the caller after reset
 */
`timescale 1ns/10ps
module spio_pin_mux (
    input  wire logic analog_en,
    input  wire logic claim,
    input  wire logic claim_oe,
    input  wire logic claim_out,
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic pullup_en,
    input  wire logic slew_en,
    input  wire logic drive_sel,
    output logic      oe,
    output logic      out,
    output logic      pull_on,
    output logic      slew,
    output logic      drive
);
    always_comb begin
        if (analog_en) begin
            // analog owner: all digital drive off
            oe  = 1'b0;
            out = 1'b0;
        end else if (claim) begin
            oe  = claim_oe;
            out = claim_oe ? claim_out : latch;
        end else begin
            oe  = dir;
            out = latch;
        end
        pull_on = pullup_en & ~oe & ~analog_en;
        slew   = slew_en & ~analog_en;
        drive  = drive_sel & ~analog_en;
    end
endmodule : spio_pin_mux

// File: hdl/spio_ports.sv
/*
 * shared parallel i/o ports: seven ports, ahb-lite register slave, pad control
 * assumes peripherals drive claim/analog vectors on clk; pad_in is asynchronous
 */
`timescale 1ns/10ps
module spio_ports
    import spio_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      ce,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic [31:0]                    hrdata,
    output logic                           hresp,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] pad_in,
    output logic [spio_pkg::PIN_COUNT-1:0] pad_oe,
    output logic [spio_pkg::PIN_COUNT-1:0] pad_out,
    output logic [spio_pkg::PIN_COUNT-1:0] pad_pullup,
    output logic [spio_pkg::PIN_COUNT-1:0] pad_slew,
    output logic [spio_pkg::PIN_COUNT-1:0] pad_drive,
    output logic [spio_pkg::PIN_COUNT-1:0] pin_level,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] periph_claim,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] periph_oe,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] periph_out,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] analog_en
);
    import spio_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ_WAIT,
        ST_READ_DONE
    } spio_bus_t;

    spio_bus_t             state;
    spio_bus_t             next_state;
    logic [ADDR_W-1:0]     addr_q;
    logic                  claim_armed;
    logic [PIN_COUNT-1:0]  latch;
    logic [PIN_COUNT-1:0]  dir;
    logic [PIN_COUNT-1:0]  pullup_en;
    logic [PIN_COUNT-1:0]  slew_en;
    logic [PIN_COUNT-1:0]  drive_sel;
    logic [PIN_COUNT-1:0]  claim_g;
    logic [PIN_COUNT-1:0]  next_oe;
    logic [PIN_COUNT-1:0]  next_out;
    logic [PIN_COUNT-1:0]  next_pullup;
    logic [PIN_COUNT-1:0]  next_slew;
    logic [PIN_COUNT-1:0]  next_drive;
    logic [PIN_COUNT-1:0]  read_view;
    logic [31:0]           next_rdata;
    logic                  accept;

    // byte address of a port register
    function automatic logic [ADDR_W-1:0] reg_addr(input int p, input spio_reg_t kind);
        logic [ADDR_W-1:0] idx;
        idx = ADDR_W'(p);
        unique case (kind)
            REG_DATA:   reg_addr = LOW_PAGE_BASE + idx * LOW_STRIDE + DATA_OFS;
            REG_DIR:    reg_addr = LOW_PAGE_BASE + idx * LOW_STRIDE + DIR_OFS;
            REG_PULLUP: reg_addr = HIGH_PAGE_BASE + idx * HIGH_STRIDE + PULLUP_OFS;
            REG_SLEW:   reg_addr = HIGH_PAGE_BASE + idx * HIGH_STRIDE + SLEW_OFS;
            REG_DRIVE:  reg_addr = HIGH_PAGE_BASE + idx * HIGH_STRIDE + DRIVE_OFS;
            default:    reg_addr = '0;
        endcase
    endfunction : reg_addr

    // one port's bits of a flat pin vector, zero above the port width
    function automatic logic [31:0] port_field(input logic [PIN_COUNT-1:0] vec, input int p);
        logic [31:0] f;
        f = '0;
        for (int n = 0; n < MAX_WIDTH; n++) begin
            if (n < PORT_WIDTH[p]) begin
                f[n] = vec[PORT_BASE[p] + n];
            end
        end
        port_field = f;
    endfunction : port_field

    assign accept    = hsel && (htrans == HTRANS_NONSEQ || htrans == 2'h3) && hready;
    assign hreadyout = (state != ST_READ_WAIT);
    assign hresp     = HRESP_OKAY;

    // bus phase tracking
    always_comb begin
        next_state = ST_IDLE;
        unique case (state)
            ST_READ_WAIT: next_state = ST_READ_DONE;
            ST_IDLE, ST_WRITE, ST_READ_DONE: begin
                if (accept) begin
                    next_state = hwrite ? ST_WRITE : ST_READ_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state  <= ST_IDLE;
            addr_q <= '0;
        end else if (ce) begin
            state <= next_state;
            if (accept) begin
                addr_q <= haddr[ADDR_W-1:0];
            end
        end
    end

    // peripheral claims stay ignored through the first clock-enabled edge after reset release
    always_ff @(posedge clk) begin
        if (!rstn) begin
            claim_armed <= 1'b0;
        end else if (ce) begin
            claim_armed <= 1'b1;
        end
    end

    assign claim_g = claim_armed ? periph_claim : '0;

    // low page: data latch and direction
    always_ff @(posedge clk) begin
        if (!rstn) begin
            latch <= LATCH_RST;
            dir   <= DIR_RST;
        end else if (ce && state == ST_WRITE) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int n = 0; n < MAX_WIDTH; n++) begin
                    if (n < PORT_WIDTH[p]) begin
                        if (addr_q == reg_addr(p, REG_DATA)) begin
                            latch[PORT_BASE[p] + n] <= hwdata[n];
                        end
                        if (addr_q == reg_addr(p, REG_DIR)) begin
                            dir[PORT_BASE[p] + n] <= hwdata[n];
                        end
                    end
                end
            end
        end
    end

    // high page: pullup, slew, drive
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pullup_en <= PULLUP_RST;
            slew_en   <= SLEW_RST;
            drive_sel <= DRIVE_RST;
        end else if (ce && state == ST_WRITE) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int n = 0; n < MAX_WIDTH; n++) begin
                    if (n < PORT_WIDTH[p]) begin
                        if (addr_q == reg_addr(p, REG_PULLUP)) begin
                            pullup_en[PORT_BASE[p] + n] <= hwdata[n];
                        end
                        if (addr_q == reg_addr(p, REG_SLEW)) begin
                            slew_en[PORT_BASE[p] + n] <= hwdata[n];
                        end
                        if (addr_q == reg_addr(p, REG_DRIVE)) begin
                            drive_sel[PORT_BASE[p] + n] <= hwdata[n];
                        end
                    end
                end
            end
        end
    end

    // data read view: direction picks pin or latch, analog bits read zero
    assign read_view = ~analog_en & ((dir & latch) | (~dir & pin_level));

    always_comb begin
        next_rdata = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (addr_q == reg_addr(p, REG_DATA)) begin
                next_rdata = port_field(read_view, p);
            end
            if (addr_q == reg_addr(p, REG_DIR)) begin
                next_rdata = port_field(dir, p);
            end
            if (addr_q == reg_addr(p, REG_PULLUP)) begin
                next_rdata = port_field(pullup_en, p);
            end
            if (addr_q == reg_addr(p, REG_SLEW)) begin
                next_rdata = port_field(slew_en, p);
            end
            if (addr_q == reg_addr(p, REG_DRIVE)) begin
                next_rdata = port_field(drive_sel, p);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hrdata <= '0;
        end else if (ce && state == ST_READ_WAIT) begin
            hrdata <= next_rdata;
        end
    end

    spio_sync #(
        .WIDTH(PIN_COUNT)
    ) u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .async_in (pad_in),
        .level    (pin_level)
    );

    // one mux per pin
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        spio_pin_mux u_mux (
            .analog_en (analog_en[i]),
            .claim     (claim_g[i]),
            .claim_oe  (periph_oe[i]),
            .claim_out (periph_out[i]),
            .dir       (dir[i]),
            .latch     (latch[i]),
            .pullup_en (pullup_en[i]),
            .slew_en   (slew_en[i]),
            .drive_sel (drive_sel[i]),
            .oe        (next_oe[i]),
            .out       (next_out[i]),
            .pull_on   (next_pullup[i]),
            .slew      (next_slew[i]),
            .drive     (next_drive[i])
        );
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pad_oe     <= '0;
            pad_out    <= '0;
            pad_pullup <= '0;
            pad_slew   <= SLEW_RST;
            pad_drive  <= '0;
        end else if (ce) begin
            pad_oe     <= next_oe;
            pad_out    <= next_out;
            pad_pullup <= next_pullup;
            pad_slew   <= next_slew;
            pad_drive  <= next_drive;
        end
    end

    sequence rd_issue_s;
        accept && !hwrite && ce;
    endsequence

    sequence rd_answer_s;
        !hreadyout ##1 hreadyout;
    endsequence

    reset_dir_a: assert property (@(posedge clk) $rose(rstn) |-> dir == '0 && latch == '0)
        else $error("direction not cleared after reset");
    reset_ctl_a: assert property (@(posedge clk) $rose(rstn) |-> slew_en == SLEW_RST && pullup_en == '0 && drive_sel == '0)
        else $error("pin control reset values wrong");
    claim_block_a: assert property (@(posedge clk) $rose(rstn) |-> !claim_armed && claim_g == '0)
        else $error("peripheral claim active right after reset");
    analog_off_a: assert property (@(posedge clk) disable iff (!rstn) ce |=> (pad_oe & $past(analog_en)) == '0)
        else $error("analog pin still driven");
    claim_dir_a: assert property (@(posedge clk) disable iff (!rstn)
        ce |=> ((pad_oe ^ $past(periph_oe)) & $past(claim_g & ~analog_en)) == '0)
        else $error("claimed pin direction not from peripheral");
    claim_out_a: assert property (@(posedge clk) disable iff (!rstn)
        ce |=> ((pad_out ^ $past(periph_out)) & $past(claim_g & periph_oe & ~analog_en)) == '0)
        else $error("claimed output not from peripheral");
    port_dir_a: assert property (@(posedge clk) disable iff (!rstn)
        ce |=> ((pad_oe ^ $past(dir)) & $past(~claim_g & ~analog_en)) == '0)
        else $error("unclaimed pin direction not from port");
    pullup_off_a: assert property (@(posedge clk) disable iff (!rstn) (pad_pullup & pad_oe) == '0)
        else $error("pullup on while driving");
    read_wait_a: assert property (@(posedge clk) disable iff (!rstn) rd_issue_s |=> rd_answer_s)
        else $error("read answer timing wrong");
    read_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && state == ST_READ_WAIT && addr_q == reg_addr(1, REG_DATA)) |=>
        (hrdata[3:0] & $past(analog_en[7:4])) == 4'h0)
        else $error("analog bit read nonzero");
endmodule : spio_ports

// File: dv/spio_pad_model.sv
/*
 * pad model: resolves each pin level from the block's drive, an outside driver and the pullup
 * assumes the bench drives ext_en and ext_val on clk; a pin nobody drives changes every cycle
 */
`timescale 1ns/10ps
module spio_pad_model (
    input  wire logic                           clk,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] pad_oe,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] pad_out,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] pad_pullup,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] ext_en,
    input  wire logic [spio_pkg::PIN_COUNT-1:0] ext_val,
    output logic      [spio_pkg::PIN_COUNT-1:0] pad_in
);
    import spio_pkg::*;
    logic [PIN_COUNT-1:0] last = '0;
    logic [PIN_COUNT-1:0] drv;
    logic [PIN_COUNT-1:0] val;
    // block drive wins, then the outside driver, then the pullup
    assign drv = pad_oe | ext_en | pad_pullup;
    assign val = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & pad_pullup);
    // floating pins never hold a level
    assign pad_in = (drv & val) | (~drv & ~last);
    always_ff @(posedge clk) begin
        last <= pad_in;
    end
endmodule : spio_pad_model

// File: dv/tb.sv
/*
 * testbench: ahb-lite register tests and pad checks against a shadow of the registers
 * assumes one slave, hready looped from hreadyout, ce high except in the freeze test
 */
`timescale 1ns/10ps
module tb;
    import spio_pkg::*;
    logic        clk, rstn, ce, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [37:0] pad_in, pad_oe, pad_out, pad_pullup, pad_slew, pad_drive, pin_level;
    logic [37:0] claim, p_oe, p_out, analog, ext_en, ext_val, e_oe, e_out;
    logic [37:0] sh [5];
    logic [31:0] rd;
    int          failures, num_checks, cycles;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    spio_ports dut (.clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pad_in(pad_in), .pad_oe(pad_oe), .pad_out(pad_out),
        .pad_pullup(pad_pullup), .pad_slew(pad_slew), .pad_drive(pad_drive), .pin_level(pin_level),
        .periph_claim(claim), .periph_oe(p_oe), .periph_out(p_out), .analog_en(analog));
    spio_pad_model pads (.clk(clk), .pad_oe(pad_oe), .pad_out(pad_out), .pad_pullup(pad_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_pins(input logic [37:0] got, input logic [37:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_pins

    // ready and read data are stable in the low half, so this is their value at the edge
    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        do begin
            @(negedge clk);
            r = hreadyout;
            d = hrdata;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask : wait_rdy

    task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {20'h0, a};
        hwrite <= wr;
        wait_rdy(d);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(d);
    endtask : bus

    function automatic logic [11:0] addr_of(spio_reg_t k, int p);
        logic [11:0] lo, hi;
        lo = 12'(LOW_PAGE_BASE + LOW_STRIDE * p);
        hi = 12'(HIGH_PAGE_BASE + HIGH_STRIDE * p);
        case (k)
            REG_DATA:   return lo + DATA_OFS;
            REG_DIR:    return lo + DIR_OFS;
            REG_PULLUP: return hi + PULLUP_OFS;
            REG_SLEW:   return hi + SLEW_OFS;
            default:    return hi + DRIVE_OFS;
        endcase
    endfunction : addr_of

    task automatic wr_reg(input spio_reg_t k, input int p, input logic [31:0] v);
        bus(addr_of(k, p), 1'b1, v, rd);
        for (int j = 0; j < PORT_WIDTH[p]; j++) begin
            sh[k][PORT_BASE[p] + j] = v[j];
        end
    endtask : wr_reg

    function automatic logic [31:0] exp_reg(spio_reg_t k, int p);
        logic [31:0] v;
        int          i;
        v = '0;
        for (int j = 0; j < PORT_WIDTH[p]; j++) begin
            i = PORT_BASE[p] + j;
            if (k != REG_DATA) begin
                v[j] = sh[k][i];
            end else if (!analog[i]) begin
                v[j] = sh[REG_DIR][i] ? sh[REG_DATA][i] : (e_oe[i] ? e_out[i] : ext_val[i]);
            end
        end
        return v;
    endfunction : exp_reg

    task automatic check_pads;
        logic [37:0] pu, sl, dr, lv;
        for (int i = 0; i < PIN_COUNT; i++) begin
            e_oe[i]  = claim[i] ? p_oe[i] : sh[REG_DIR][i];
            e_out[i] = (claim[i] && p_oe[i]) ? p_out[i] : sh[REG_DATA][i];
            pu[i]    = sh[REG_PULLUP][i] & ~e_oe[i];
            sl[i]    = sh[REG_SLEW][i];
            dr[i]    = sh[REG_DRIVE][i];
            if (analog[i]) begin
                {e_oe[i], e_out[i], pu[i], sl[i], dr[i]} = 5'h00;
            end
            lv[i] = e_oe[i] ? e_out[i] : ext_val[i];
        end
        cmp_pins(pad_oe, e_oe, "oe");
        cmp_pins(pad_out, e_out, "out");
        cmp_pins(pad_pullup, pu, "pullup");
        cmp_pins(pad_slew, sl, "slew");
        cmp_pins(pad_drive, dr, "drive");
        cmp_pins(pin_level, lv, "level");
    endtask : check_pads

    task automatic check_all(input string name);
        repeat (6) @(posedge clk);
        @(negedge clk);
        check_pads();
        @(posedge clk);
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int k = 0; k < 5; k++) begin
                bus(addr_of(spio_reg_t'(k), p), 1'b0, 32'h0, rd);
                cmp_word(rd, exp_reg(spio_reg_t'(k), p), "read");
            end
        end
        cmp_word({31'h0, hresp}, {31'h0, HRESP_OKAY}, "resp");
        $display("test %s done", name);
    endtask : check_all

    task automatic reset_shadow;
        sh[REG_DATA]   = LATCH_RST;
        sh[REG_DIR]    = DIR_RST;
        sh[REG_PULLUP] = PULLUP_RST;
        sh[REG_SLEW]   = SLEW_RST;
        sh[REG_DRIVE]  = DRIVE_RST;
    endtask : reset_shadow

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        {rstn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        ce = 1'b1;
        {claim, p_oe, p_out, analog} = '0;
        ext_en = '1;
        ext_val = 38'h2A_5A5A_C3C3;
        reset_shadow();
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        check_all("reset");
        foreach (ext_val[i]) begin
            if (i < 2) begin
                bus(i ? 12'h170 : 12'h038, 1'b1, 32'hFFFF_FFFF, rd);
                bus(i ? 12'h170 : 12'h038, 1'b0, 32'h0, rd);
                cmp_word(rd, 32'h0, "unmapped");
            end
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            wr_reg(REG_DATA, p, 32'h5A5A_5A5A ^ 32'(p));
            wr_reg(REG_DIR, p, 32'hFFFF_FF33);
            wr_reg(REG_PULLUP, p, 32'hFFFF_FFFF);
            wr_reg(REG_SLEW, p, 32'h0000_0055 ^ 32'(p));
            wr_reg(REG_DRIVE, p, 32'hFFFF_FF0F);
        end
        check_all("config");
        claim <= 38'h00_0000_3FF0;
        p_oe  <= 38'h00_0000_2A50;
        p_out <= 38'h00_0000_1C30;
        check_all("claim");
        analog <= 38'h00_0003_C0C0;
        check_all("analog");
        claim  <= '0;
        analog <= '0;
        check_all("release");
        ce     <= 1'b0;
        analog <= '1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp_pins(pad_oe, e_oe, "oe frozen");
        @(posedge clk);
        ce     <= 1'b1;
        analog <= '0;
        claim <= '1;
        p_oe  <= '1;
        p_out <= '1;
        rstn  <= 1'b0;
        reset_shadow();
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp_pins(pad_oe, 38'h0, "oe in reset");
        cmp_pins(pad_slew, SLEW_RST, "slew in reset");
        @(posedge clk);
        rstn  <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        cmp_pins(pad_oe, 38'h0, "oe after reset");
        @(posedge clk);
        claim <= '0;
        check_all("second reset");
        report_and_stop();
    end
endmodule : tb
